// [src/fec_hdr_regs.svh]
// Constants of the repair header framer: field positions, fixed values, reset values.
// Assumes 32-bit header words with bit 31 sent first.
`ifndef FEC_HDR_REGS_SVH
`define FEC_HDR_REGS_SVH

// ==========================================
// Fixed field values
`define FEC_RTP_VERSION 2'h2
`define FEC_TX_MARKER 1'h0
`define FEC_CC_NONE 4'h0

// ==========================================
// Field positions of the first header word (RTP and FEC alike)
`define FEC_TOP_HI 31
`define FEC_TOP_LO 30
`define FEC_R_POS 31
`define FEC_F_POS 30
`define FEC_P_POS 29
`define FEC_X_POS 28
`define FEC_CC_HI 27
`define FEC_CC_LO 24
`define FEC_M_POS 23
`define FEC_PT_HI 22
`define FEC_PT_LO 16
`define FEC_LOW_HI 15
`define FEC_LOW_LO 0

// ==========================================
// Reset values and generator constants
`define FEC_SN_RST 16'h0000
`define FEC_SSRC_RST 32'h00000000
`define FEC_TS_RST 32'h00000000
`define FEC_LFSR_SEED 32'hACE12468
`define FEC_LFSR_TAPS 32'h80200003
`define FEC_TS_DIV_DEFAULT 1

`endif

// [src/fec_hdr_pkg.sv]
// Types of the repair header framer: state enums and the packed state records.
// Assumes fec_hdr_regs.svh is on the include path.
package fec_hdr_pkg;

  // ==========================================
  // State machines
  typedef enum logic [2:0] {
    TX_IDLE, TX_W0, TX_TS, TX_SSRC, TX_CSRC, TX_F0, TX_F1, TX_F2
  } tx_state_e;

  typedef enum logic [2:0] {
    RX_W0, RX_TS, RX_SSRC, RX_CSRC, RX_F0, RX_F1, RX_F2, RX_SKIP
  } rx_state_e;

  // ==========================================
  // Packed state records
  typedef struct packed {
    logic [31:0] val;
  } lfsr_s;

  typedef struct packed {
    logic init;
    logic [31:0] ssrc;
    logic [15:0] sn;
    logic [31:0] ts;
    logic [15:0] ts_div;
    logic coll_pend;
    tx_state_e tx_st;
    logic tx_retx;
    logic [3:0] tx_cc;
    logic [3:0] tx_idx;
    logic [31:0] pkt_ts;
    logic [31:0] rec_w0;
    logic [31:0] rec_ts;
    logic [31:0] rec_ssrc;
    logic [31:0] tx_data;
    logic tx_done;
    rx_state_e rx_st;
    logic [3:0] rx_cc;
    logic [3:0] rx_cnt;
    logic [31:0] rx_w0;
    logic [31:0] rx_ts;
    logic [31:0] rx_ssrc;
    logic rx_hdr_valid;
    logic rx_drop;
    logic collide;
  } framer_s;

endpackage : fec_hdr_pkg

// [src/lfsr_rand.sv]
// Free-running 32-bit Galois LFSR used as the source of unpredictable values.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`include "fec_hdr_regs.svh"

module lfsr_rand import fec_hdr_pkg::*; #(
  parameter logic [31:0] SEED = `FEC_LFSR_SEED,
  parameter logic [31:0] TAPS = `FEC_LFSR_TAPS
) (
  input wire logic clk, // System clock
  input wire logic rstn, // Asynchronous reset, active low
  output logic [31:0] value // Current pseudo-random word
);

  lfsr_s s_reg;
  lfsr_s s_next;

  // ==========================================
  // Shift
  always_comb begin
    s_next = s_reg;
    s_next.val = {1'b0, s_reg.val[31:1]} ^ (s_reg.val[0] ? TAPS : 32'h00000000);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg.val <= SEED;
    end else begin
      s_reg <= s_next;
    end
  end

  assign value = s_reg.val;

endmodule : lfsr_rand

// [src/fec_repair_header_framer.sv]
// Repair packet header framer: emits the RTP header and the common FEC header
// words of outgoing repair packets, and checks and splits those of incoming ones.
// Assumes the payload, the mask or L/D bodies and the parity are handled elsewhere,
// and that the receive stream delivers one 32-bit word per valid cycle.
//
// Contract
// - Version 2 only, sent and accepted
// - Repair padding bit is its own
// - Repair extension bit is its own
// - CSRC count and list name protected streams
// - Marker sent 0, ignored on receive
// - Sequence number rises by one, wraps
// - Initial sequence number is random
// - Timestamp reflects transmission moment
// - Repair stream identifier is random
// - Identifier collision detected and resolved
// - R and F select header layout
// - R=F=1 never sent, ignored received
// - R is 1 for retransmission only
// - F is 0 whenever R is 1
// - FEC header carries P,X,CC,M,PT recovery
// - Repair payload covers octets after 12 bytes
// - 16-bit length recovery field
// - 32-bit timestamp recovery field
`timescale 1ns/1ps
`include "fec_hdr_regs.svh"

module fec_repair_header_framer import fec_hdr_pkg::*; #(
  parameter int TS_DIV = `FEC_TS_DIV_DEFAULT
) (
  input wire logic clk, // System clock, 25 MHz
  input wire logic rstn, // Asynchronous reset, active low
  // Transmit request
  input wire logic tx_start, // Start a repair packet header
  input wire logic tx_retx, // 1 retransmission, 0 parity repair
  input wire logic tx_fixed, // Parity layout: 1 fixed L/D, 0 mask
  input wire logic tx_pad, // Repair packet carries padding
  input wire logic tx_ext, // Repair packet carries extensions
  input wire logic [6:0] tx_pt, // Repair payload type
  input wire logic [3:0] tx_cc, // Number of protected streams
  input wire logic [31:0] csrc_word, // Protected stream id at csrc_idx
  output logic [3:0] csrc_idx, // Index of the id wanted next
  input wire logic src_p, // Padding recovery
  input wire logic src_x, // Extension recovery
  input wire logic [3:0] src_cc, // CSRC count recovery
  input wire logic src_m, // Marker recovery
  input wire logic [6:0] src_pt, // Payload type recovery
  input wire logic [15:0] src_len_sn, // Length recovery, or SN when retransmitting
  input wire logic [31:0] src_ts, // Timestamp recovery
  input wire logic [31:0] src_ssrc, // Source stream id for retransmission
  output logic tx_idle, // Ready to take tx_start
  // Transmit word stream
  output logic tx_valid, // Header word valid
  output logic [31:0] tx_data, // Header word
  output logic tx_last, // Last header word
  input wire logic tx_ready, // Sink takes the word
  output logic tx_done, // Header fully sent
  output logic [31:0] own_ssrc, // Current repair stream id
  output logic [15:0] own_sn, // Sequence number of the next packet
  // Receive word stream
  input wire logic rx_valid, // Received word valid
  input wire logic [31:0] rx_data, // Received word
  input wire logic rx_last, // Last word of the packet
  input wire logic [6:0] rx_pt, // Payload type agreed for repair
  output logic rx_hdr_valid, // Header accepted, fields below valid
  output logic rx_drop, // Packet discarded
  output logic [3:0] rx_csrc_cnt, // Protected stream count received
  output logic rec_r, // Received R flag
  output logic rec_f, // Received F flag
  output logic rec_p, // Padding recovery
  output logic rec_x, // Extension recovery
  output logic [3:0] rec_cc, // CSRC count recovery
  output logic rec_m, // Marker recovery
  output logic [6:0] rec_pt, // Payload type recovery
  output logic [15:0] rec_len_sn, // Length recovery, or SN of retransmission
  output logic [31:0] rec_ts, // Timestamp recovery
  output logic [31:0] rec_ssrc, // Source id of a retransmission
  output logic ssrc_collision // Pulse: peer uses our stream id
);

  framer_s s_reg;
  framer_s s_next;
  logic [31:0] rnd;
  logic [3:0] cc_eff;

  // ==========================================
  // Helpers
  function automatic logic [31:0] pack_w0(
    input logic [1:0] top,
    input logic p,
    input logic x,
    input logic [3:0] cc,
    input logic m,
    input logic [6:0] pt,
    input logic [15:0] low
  );
    pack_w0 = {top, p, x, cc, m, pt, low};
  endfunction : pack_w0

  lfsr_rand u_rand (
    .clk(clk),
    .rstn(rstn),
    .value(rnd)
  );

  // Retransmissions name their source inside the FEC header, not in the list
  assign cc_eff = tx_retx ? `FEC_CC_NONE : tx_cc;

  // ==========================================
  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.tx_done = 1'b0;
    s_next.rx_hdr_valid = 1'b0;
    s_next.rx_drop = 1'b0;
    s_next.collide = 1'b0;

    // Timestamp clock for outgoing packets
    if (s_reg.ts_div == 16'(TS_DIV - 1)) begin
      s_next.ts_div = 16'h0000;
      s_next.ts = s_reg.ts + 32'h00000001;
    end else begin
      s_next.ts_div = s_reg.ts_div + 16'h0001;
    end

    // Identifier and SN are drawn once after reset; a new id waits for an idle sender
    if (!s_reg.init) begin
      s_next.init = 1'b1;
      s_next.ssrc = rnd;
      s_next.sn = rnd[31:16] ^ rnd[15:0];
    end else if (s_reg.coll_pend && s_reg.tx_st == TX_IDLE) begin
      s_next.ssrc = rnd ^ s_reg.ssrc;
      s_next.coll_pend = 1'b0;
    end

    // ==========================================
    // Transmit sequencer
    case (s_reg.tx_st)
      TX_IDLE: begin
        if (tx_start && s_reg.init) begin
          s_next.tx_retx = tx_retx;
          s_next.tx_cc = cc_eff;
          s_next.tx_idx = 4'h0;
          s_next.pkt_ts = s_reg.ts;
          s_next.tx_data = pack_w0(`FEC_RTP_VERSION, tx_pad, tx_ext, cc_eff,
                                   `FEC_TX_MARKER, tx_pt, s_reg.sn);
          s_next.rec_w0 = pack_w0({tx_retx, tx_fixed & ~tx_retx}, src_p, src_x, src_cc,
                                  src_m, src_pt, src_len_sn);
          s_next.rec_ts = src_ts;
          s_next.rec_ssrc = src_ssrc;
          s_next.tx_st = TX_W0;
        end
      end
      TX_W0: begin
        if (tx_ready) begin
          s_next.tx_data = s_reg.pkt_ts;
          s_next.tx_st = TX_TS;
        end
      end
      TX_TS: begin
        if (tx_ready) begin
          s_next.tx_data = s_reg.ssrc;
          s_next.tx_st = TX_SSRC;
        end
      end
      TX_SSRC: begin
        if (tx_ready) begin
          if (s_reg.tx_cc != `FEC_CC_NONE) begin
            s_next.tx_data = csrc_word;
            s_next.tx_idx = s_reg.tx_idx + 4'h1;
            s_next.tx_st = TX_CSRC;
          end else begin
            s_next.tx_data = s_reg.rec_w0;
            s_next.tx_st = TX_F0;
          end
        end
      end
      TX_CSRC: begin
        if (tx_ready) begin
          if (s_reg.tx_idx == s_reg.tx_cc) begin
            s_next.tx_data = s_reg.rec_w0;
            s_next.tx_st = TX_F0;
          end else begin
            s_next.tx_data = csrc_word;
            s_next.tx_idx = s_reg.tx_idx + 4'h1;
          end
        end
      end
      TX_F0: begin
        if (tx_ready) begin
          s_next.tx_data = s_reg.rec_ts;
          s_next.tx_st = TX_F1;
        end
      end
      TX_F1: begin
        if (tx_ready) begin
          if (s_reg.tx_retx) begin
            s_next.tx_data = s_reg.rec_ssrc;
            s_next.tx_st = TX_F2;
          end else begin
            s_next.tx_st = TX_IDLE;
            s_next.tx_done = 1'b1;
            s_next.sn = s_reg.sn + 16'h0001;
          end
        end
      end
      TX_F2: begin
        if (tx_ready) begin
          s_next.tx_st = TX_IDLE;
          s_next.tx_done = 1'b1;
          s_next.sn = s_reg.sn + 16'h0001;
        end
      end
      default: begin
        s_next.tx_st = TX_IDLE;
      end
    endcase

    // ==========================================
    // Receive parser
    if (rx_valid) begin
      case (s_reg.rx_st)
        RX_W0: begin
          // Marker is not looked at; version is checked before any flag
          if (rx_data[`FEC_TOP_HI:`FEC_TOP_LO] != `FEC_RTP_VERSION) begin
            s_next.rx_drop = 1'b1;
            s_next.rx_st = RX_SKIP;
          end else if (rx_data[`FEC_PT_HI:`FEC_PT_LO] != rx_pt) begin
            s_next.rx_drop = 1'b1;
            s_next.rx_st = RX_SKIP;
          end else begin
            s_next.rx_cc = rx_data[`FEC_CC_HI:`FEC_CC_LO];
            s_next.rx_cnt = 4'h0;
            s_next.rx_st = RX_TS;
          end
        end
        RX_TS: begin
          s_next.rx_st = RX_SSRC;
        end
        RX_SSRC: begin
          if (rx_data == s_reg.ssrc && s_reg.init) begin
            s_next.collide = 1'b1;
            s_next.coll_pend = 1'b1;
          end
          s_next.rx_st = (s_reg.rx_cc != `FEC_CC_NONE) ? RX_CSRC : RX_F0;
        end
        RX_CSRC: begin
          s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
          if (s_reg.rx_cnt + 4'h1 == s_reg.rx_cc) begin
            s_next.rx_st = RX_F0;
          end
        end
        RX_F0: begin
          if (rx_data[`FEC_R_POS] && rx_data[`FEC_F_POS]) begin
            s_next.rx_drop = 1'b1;
            s_next.rx_st = RX_SKIP;
          end else begin
            s_next.rx_w0 = rx_data;
            s_next.rx_st = RX_F1;
          end
        end
        RX_F1: begin
          s_next.rx_ts = rx_data;
          if (s_reg.rx_w0[`FEC_R_POS]) begin
            s_next.rx_st = RX_F2;
          end else begin
            s_next.rx_hdr_valid = 1'b1;
            s_next.rx_st = RX_SKIP;
          end
        end
        RX_F2: begin
          s_next.rx_ssrc = rx_data;
          s_next.rx_hdr_valid = 1'b1;
          s_next.rx_st = RX_SKIP;
        end
        RX_SKIP: begin
          // Repair payload words pass by for the decoder
          s_next.rx_st = RX_SKIP;
        end
        default: begin
          s_next.rx_st = RX_W0;
        end
      endcase
      // A packet that ends inside its header is discarded
      if (rx_last) begin
        if (s_next.rx_st != RX_SKIP && !s_next.rx_hdr_valid && !s_next.rx_drop) begin
          s_next.rx_drop = 1'b1;
        end
        s_next.rx_st = RX_W0;
      end
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '{
        init: 1'b0,
        ssrc: `FEC_SSRC_RST,
        sn: `FEC_SN_RST,
        ts: `FEC_TS_RST,
        ts_div: 16'h0000,
        coll_pend: 1'b0,
        tx_st: TX_IDLE,
        tx_retx: 1'b0,
        tx_cc: 4'h0,
        tx_idx: 4'h0,
        pkt_ts: 32'h00000000,
        rec_w0: 32'h00000000,
        rec_ts: 32'h00000000,
        rec_ssrc: 32'h00000000,
        tx_data: 32'h00000000,
        tx_done: 1'b0,
        rx_st: RX_W0,
        rx_cc: 4'h0,
        rx_cnt: 4'h0,
        rx_w0: 32'h00000000,
        rx_ts: 32'h00000000,
        rx_ssrc: 32'h00000000,
        rx_hdr_valid: 1'b0,
        rx_drop: 1'b0,
        collide: 1'b0
      };
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================
  // Outputs
  assign tx_idle = (s_reg.tx_st == TX_IDLE) && s_reg.init;
  assign tx_valid = (s_reg.tx_st != TX_IDLE);
  assign tx_data = s_reg.tx_data;
  assign tx_last = (s_reg.tx_st == TX_F2) || (s_reg.tx_st == TX_F1 && !s_reg.tx_retx);
  assign tx_done = s_reg.tx_done;
  assign csrc_idx = s_reg.tx_idx;
  assign own_ssrc = s_reg.ssrc;
  assign own_sn = s_reg.sn;

  assign rx_hdr_valid = s_reg.rx_hdr_valid;
  assign rx_drop = s_reg.rx_drop;
  assign rx_csrc_cnt = s_reg.rx_cc;
  assign rec_r = s_reg.rx_w0[`FEC_R_POS];
  assign rec_f = s_reg.rx_w0[`FEC_F_POS];
  assign rec_p = s_reg.rx_w0[`FEC_P_POS];
  assign rec_x = s_reg.rx_w0[`FEC_X_POS];
  assign rec_cc = s_reg.rx_w0[`FEC_CC_HI:`FEC_CC_LO];
  assign rec_m = s_reg.rx_w0[`FEC_M_POS];
  assign rec_pt = s_reg.rx_w0[`FEC_PT_HI:`FEC_PT_LO];
  assign rec_len_sn = s_reg.rx_w0[`FEC_LOW_HI:`FEC_LOW_LO];
  assign rec_ts = s_reg.rx_ts;
  assign rec_ssrc = s_reg.rx_ssrc;
  assign ssrc_collision = s_reg.collide;

endmodule : fec_repair_header_framer

// [bench/fec_framer_properties.sv]
// Checker for the repair header framer, bound to its top module.
// Assumes only the framer's ports; header word positions are tracked locally.
`timescale 1ns/1ps

module fec_framer_properties (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic tx_start, // Start request
  input wire logic tx_retx, // Retransmission
  input wire logic tx_fixed, // Fixed layout
  input wire logic tx_pad, // Own padding
  input wire logic tx_ext, // Own extension
  input wire logic [3:0] tx_cc, // Stream count
  input wire logic tx_idle, // Idle
  input wire logic tx_valid, // Word valid
  input wire logic [31:0] tx_data, // Word
  input wire logic tx_last, // Last word
  input wire logic tx_ready, // Sink ready
  input wire logic tx_done, // Done pulse
  input wire logic [15:0] own_sn, // Next sequence number
  input wire logic rx_valid, // Rx valid
  input wire logic [31:0] rx_data, // Rx word
  input wire logic rx_last, // Rx last
  input wire logic [6:0] rx_pt, // Agreed type
  input wire logic rx_drop // Drop pulse
);
  // ==========================================
  // Word position tracking
  logic [4:0] widx_reg;
  logic [3:0] cc_reg;
  logic retx_reg, fix_reg, pad_reg, ext_reg, rx_first_reg;
  logic w0, fw0;
  assign w0 = tx_valid && widx_reg == 5'h0;
  assign fw0 = tx_valid && widx_reg == (retx_reg ? 5'h3 : 5'h3 + {1'b0, cc_reg});

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      widx_reg <= 5'h0;
      {cc_reg, retx_reg, fix_reg, pad_reg, ext_reg} <= 8'h00;
      rx_first_reg <= 1'b1;
    end else begin
      if (tx_start && tx_idle) begin
        widx_reg <= 5'h0;
        {cc_reg, retx_reg, fix_reg, pad_reg, ext_reg} <= {tx_cc, tx_retx, tx_fixed, tx_pad, tx_ext};
      end else if (tx_valid && tx_ready) begin
        widx_reg <= widx_reg + 5'h1;
      end
      if (rx_valid) begin
        rx_first_reg <= rx_last;
      end
    end
  end

  // ==========================================
  // Properties
  a_tx_version: assert property (@(posedge clk) disable iff (!rstn)
    w0 |-> tx_data[31:30] == 2'h2) else $error("repair version not 2");
  a_tx_marker: assert property (@(posedge clk) disable iff (!rstn)
    w0 |-> !tx_data[23]) else $error("repair marker set");
  a_own_bits: assert property (@(posedge clk) disable iff (!rstn)
    w0 |-> tx_data[29:28] == {pad_reg, ext_reg}) else $error("padding or extension wrong");
  a_csrc_count: assert property (@(posedge clk) disable iff (!rstn)
    w0 |-> tx_data[27:24] == (retx_reg ? 4'h0 : cc_reg)) else $error("stream count wrong");
  a_r_flag: assert property (@(posedge clk) disable iff (!rstn)
    fw0 |-> tx_data[31] == retx_reg) else $error("R flag wrong");
  a_f_flag: assert property (@(posedge clk) disable iff (!rstn)
    fw0 |-> tx_data[30] == (fix_reg && !retx_reg)) else $error("F flag wrong");
  a_sn_step: assert property (@(posedge clk) disable iff (!rstn)
    tx_done |-> own_sn == $past(own_sn) + 16'h1) else $error("sequence step wrong");
  a_start_answer: assert property (@(posedge clk) disable iff (!rstn)
    tx_start && tx_idle |=> tx_valid) else $error("no word after start");
  a_word_hold: assert property (@(posedge clk) disable iff (!rstn)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("word not held");
  a_done_pulse: assert property (@(posedge clk) disable iff (!rstn)
    tx_valid && tx_ready && tx_last |=> tx_done ##1 !tx_done) else $error("done pulse wrong");
  a_rx_version: assert property (@(posedge clk) disable iff (!rstn)
    rx_valid && rx_first_reg && rx_data[31:30] != 2'h2 |=> rx_drop) else $error("bad version kept");
  a_rx_type: assert property (@(posedge clk) disable iff (!rstn)
    rx_valid && rx_first_reg && rx_data[22:16] != rx_pt |=> rx_drop) else $error("bad type kept");
endmodule : fec_framer_properties

bind fec_repair_header_framer fec_framer_properties chk (.clk(clk), .rstn(rstn),
  .tx_start(tx_start), .tx_retx(tx_retx), .tx_fixed(tx_fixed), .tx_pad(tx_pad),
  .tx_ext(tx_ext), .tx_cc(tx_cc), .tx_idle(tx_idle), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .tx_done(tx_done),
  .own_sn(own_sn), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
  .rx_pt(rx_pt), .rx_drop(rx_drop));

// [bench/remote_peer.sv]
// Model of the remote endpoint: takes repair header words, sends received words.
// Assumes the bench fills rxq with {last, word}; it drives at the falling edge.
`timescale 1ns/1ps

module remote_peer (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic slow, // Stall the framer now and then
  output logic tx_ready, // Takes a header word
  output logic rx_valid, // Word valid
  output logic [31:0] rx_data, // Word
  output logic rx_last // Last word of packet
);
  logic [32:0] rxq[$];
  logic [2:0] cnt;

  always @(negedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 3'h0;
      {tx_ready, rx_valid, rx_last} <= 3'h0;
      rx_data <= 32'h0;
    end else begin
      cnt <= cnt + 3'h1;
      tx_ready <= !slow || (cnt[0] ^ cnt[2]);
      if (rxq.size() > 0) begin
        {rx_last, rx_data} <= rxq.pop_front();
        rx_valid <= 1'b1;
      end else begin
        // Idle data toggles so nothing stale can pass for a word
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_data <= ~rx_data;
      end
    end
  end
endmodule : remote_peer

// [bench/test_fec_repair_header_framer.sv]
// Self-checking bench of the repair header framer with the remote peer model.
// Assumes the framer, its package and the bound checker are compiled first.
`timescale 1ns/1ps

module test_fec_repair_header_framer;
  import fec_hdr_pkg::*;
  logic clk, rstn, tx_start, tx_retx, tx_fixed, tx_pad, tx_ext, src_p, src_x, src_m, slow;
  logic tx_idle, tx_valid, tx_last, tx_ready, tx_done, rx_valid, rx_last, rx_hdr_valid;
  logic rx_drop, rec_r, rec_f, rec_p, rec_x, rec_m, ssrc_collision;
  logic [6:0] tx_pt, src_pt, rx_pt, rec_pt;
  logic [3:0] tx_cc, src_cc, csrc_idx, rx_csrc_cnt, rec_cc;
  logic [15:0] src_len_sn, own_sn, rec_len_sn, sn_exp;
  logic [31:0] csrc_word, src_ts, src_ssrc, own_ssrc, rec_ts, rec_ssrc, tx_data, rx_data;
  logic [31:0] csrc_tab [16];
  logic [64:0] txq[$];
  logic [100:0] rxq[$];
  int bad_count = 0, tests_run = 0, cycles = 0, hits = 0, seed = 55500;

  fec_repair_header_framer uut (.clk, .rstn, .tx_start, .tx_retx, .tx_fixed, .tx_pad,
    .tx_ext, .tx_pt, .tx_cc, .csrc_word, .csrc_idx, .src_p, .src_x, .src_cc, .src_m,
    .src_pt, .src_len_sn, .src_ts, .src_ssrc, .tx_idle, .tx_valid, .tx_data, .tx_last,
    .tx_ready, .tx_done, .own_ssrc, .own_sn, .rx_valid, .rx_data, .rx_last, .rx_pt,
    .rx_hdr_valid, .rx_drop, .rx_csrc_cnt, .rec_r, .rec_f, .rec_p, .rec_x, .rec_cc,
    .rec_m, .rec_pt, .rec_len_sn, .rec_ts, .rec_ssrc, .ssrc_collision);
  remote_peer peer (.clk, .rstn, .slow, .tx_ready, .rx_valid, .rx_data, .rx_last);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================
  // Comparison and closing
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      bad_count++;
      final_report();
    end
  end

  // ==========================================
  // Result watchers
  always @(negedge clk) csrc_word <= csrc_tab[csrc_idx];
  always @(posedge clk) if (ssrc_collision) hits++;

  always @(posedge clk) if (rstn && tx_valid && tx_ready) begin
    logic [64:0] e;
    e = txq.pop_front();
    check("tx word", {31'h0, tx_last, tx_data & e[63:32]}, {31'h0, e[64], e[31:0] & e[63:32]});
  end

  always @(posedge clk) if (rstn && (rx_hdr_valid || rx_drop)) begin
    logic [100:0] e;
    e = rxq.pop_front();
    check("rx drop", {63'h0, rx_drop}, {63'h0, e[64]});
    if (!e[64]) begin
      check("rx fields", {rec_r, rec_f, rec_p, rec_x, rec_cc, rec_m, rec_pt,
        rec_len_sn, rec_ts}, e[63:0]);
      check("rx count", {60'h0, rx_csrc_cnt}, {60'h0, e[100:97]});
      if (e[63]) check("rx source id", {32'h0, rec_ssrc}, {32'h0, e[96:65]});
    end
  end

  // ==========================================
  // Drivers
  task automatic send(input logic r, input logic f, input logic [3:0] c);
    logic [3:0] n;
    @(negedge clk);
    while (!tx_idle) @(negedge clk);
    {tx_pad, tx_ext, src_p, src_x, src_m} = 5'($random(seed));
    {tx_pt, src_pt, src_cc} = 18'($random(seed));
    {src_len_sn, src_ts, src_ssrc} = {16'($random(seed)), $random(seed), $random(seed)};
    for (int i = 0; i < 16; i++) csrc_tab[i] = $random(seed);
    {tx_retx, tx_fixed, tx_cc, tx_start} = {r, f, c, 1'b1};
    n = r ? 4'h0 : c;
    txq.push_back({1'b0, 32'hFFFFFFFF, 2'h2, tx_pad, tx_ext, n, 1'b0, tx_pt, sn_exp});
    // Timestamp ticks once a clock at the default divider; four edges fall in reset
    txq.push_back({1'b0, 32'hFFFFFFFF, 32'(cycles - 4)});
    txq.push_back({1'b0, 32'hFFFFFFFF, own_ssrc});
    for (int i = 0; i < n; i++) txq.push_back({1'b0, 32'hFFFFFFFF, csrc_tab[i]});
    txq.push_back({1'b0, 32'hFFFFFFFF, r, f & !r, src_p, src_x, src_cc, src_m, src_pt,
      src_len_sn});
    txq.push_back({!r, 32'hFFFFFFFF, src_ts});
    if (r) txq.push_back({1'b1, 32'hFFFFFFFF, src_ssrc});
    sn_exp = sn_exp + 16'h1;
    @(negedge clk);
    tx_start = 1'b0;
  endtask : send

  task automatic rx_pkt(input logic [31:0] w0, input logic [31:0] f0, input logic [31:0] id,
      input logic drop);
    logic [31:0] t, s;
    t = $random(seed);
    s = $random(seed);
    peer.rxq.push_back({1'b0, w0});
    peer.rxq.push_back({1'b0, $random(seed)});
    peer.rxq.push_back({1'b0, id});
    for (int i = 0; i < w0[27:24]; i++) peer.rxq.push_back({1'b0, $random(seed)});
    peer.rxq.push_back({1'b0, f0});
    peer.rxq.push_back({1'b0, t});
    if (f0[31]) peer.rxq.push_back({1'b0, s});
    peer.rxq.push_back({1'b1, $random(seed)});
    rxq.push_back({w0[27:24], s, drop, f0, t});
  endtask : rx_pkt

  // ==========================================
  // Main sequence
  initial begin
    logic [31:0] rv, old_id;
    {rstn, tx_start, tx_retx, tx_fixed, tx_pad, tx_ext, src_p, src_x, src_m, slow} = 10'h0;
    {tx_pt, src_pt, tx_cc, src_cc, src_len_sn, src_ts, src_ssrc} = 102'h0;
    rx_pt = 7'h60;
    for (int i = 0; i < 16; i++) csrc_tab[i] = 32'h0;
    repeat (4) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    repeat (2) @(negedge clk);
    sn_exp = own_sn; // Start value is random, taken once
    check("start drawn", {62'h0, own_sn != 16'h0000, own_ssrc != 32'h0}, 64'h3);
    send(1'b0, 1'b0, 4'h2);
    send(1'b0, 1'b1, 4'h0);
    send(1'b1, 1'b1, 4'h9);
    slow = 1'b1;
    for (int k = 0; k < 12; k++) begin
      rv = $random(seed);
      send(rv[0], rv[1], rv[5:2]);
    end
    send(1'b0, 1'b0, 4'hF);
    slow = 1'b0;
    repeat (60) @(negedge clk);
    check("next sn", {48'h0, own_sn}, {48'h0, sn_exp});
    rx_pkt({2'h2, 2'h0, 4'h1, 1'b1, rx_pt, 16'h0001}, 32'h1234ABCD, 32'h11, 1'b0);
    rx_pkt({2'h1, 2'h0, 4'h0, 1'b0, rx_pt, 16'h0002}, 32'h0, 32'h11, 1'b1);
    rx_pkt({2'h2, 2'h0, 4'h0, 1'b0, rx_pt ^ 7'h01, 16'h0003}, 32'h0, 32'h11, 1'b1);
    rx_pkt({2'h2, 2'h0, 4'h0, 1'b0, rx_pt, 16'h0004}, 32'hC0000000, 32'h11, 1'b1);
    rx_pkt({2'h2, 2'h0, 4'h0, 1'b0, rx_pt, 16'h0005}, 32'h8765F00D, 32'h11, 1'b0);
    old_id = own_ssrc;
    rx_pkt({2'h2, 2'h0, 4'h0, 1'b0, rx_pt, 16'h0006}, 32'h4000BEEF, old_id, 1'b0);
    // A packet cut off inside its header must be dropped
    peer.rxq.push_back({1'b0, 2'h2, 2'h0, 4'h0, 1'b0, rx_pt, 16'h0007});
    peer.rxq.push_back({1'b1, 32'h0});
    rxq.push_back({4'h0, 32'h0, 1'b1, 64'h0});
    while (peer.rxq.size() > 0) @(negedge clk);
    repeat (20) @(negedge clk);
    check("collisions", 64'(hits), 64'h1);
    check("id renewed", {63'h0, own_ssrc !== old_id}, 64'h1);
    send(1'b0, 1'b0, 4'h1);
    repeat (30) @(negedge clk);
    check("queues empty", 64'(txq.size() + rxq.size()), 64'h0);
    final_report();
  end
endmodule : test_fec_repair_header_framer
